/* File: logic/bridge_err_map.svh */
`ifndef BRIDGE_ERR_MAP_SVH
`define BRIDGE_ERR_MAP_SVH
// configuration space byte offsets
`define OFS_ERR_STATUS   8'h6A
`define OFS_CLKRUN       8'h6B
`define OFS_PBASE_LO     8'h6C
`define OFS_PLIMIT_LO    8'h6E
`define OFS_PBASE_HI     8'h70
`define OFS_PLIMIT_HI    8'h74
// clock-run bit positions
`define CR_SEC_STOPPED   0
`define CR_SEC_PIN_EN    1
`define CR_PRI_KEEP      2
`define CR_PRI_PIN_EN    3
`define CR_MODE          4
`define CR_WMASK         8'h1F
// private window low write mask, low and high reset values, implied limit low bits
`define PW_LO_WMASK      16'hFFF0
`define PBASE_LO_RST     16'h0001
`define PLIMIT_LO_RST    16'h0000
`define PBASE_HI_RST     32'h00000001
`define PLIMIT_HI_RST    32'h00000000
`define PLIMIT_LOW_ONES  20'hFFFFF
// retry timeout: 2^24 attempts by default
`define RETRY_MAX_DEF    25'h1000000
`endif

/* File: logic/bridge_err_pkg.sv */
package bridge_err_pkg;
  // one configuration-space write or read request, byte-enabled dword
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_t;
  // the eight error causes, bit order as in the status byte
  typedef struct packed {
    logic master_timeout;
    logic dly_read_fail;
    logic dly_write_nodeliv;
    logic pw_master_abort;
    logic pw_target_abort;
    logic pw_nodeliv;
    logic pw_data_parity;
    logic addr_parity;
  } err_evt_t;
  // state of the secondary clock-stop sequencer
  typedef enum logic [1:0] {
    CS_RUN,
    CS_SEC_STOP,
    CS_PRI_STOP
  } clk_state_t;
endpackage

/* File: logic/private_window_match.sv */
`timescale 1ns/100ps
`include "bridge_err_map.svh"
// registered inclusive compare of an address against the 64-bit window
module private_window_match (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [63:0] base,
  input  wire logic [63:0] limit,
  input  wire logic        win_en,
  input  wire logic [63:0] addr,
  output logic             hit
);
  // empty window (base above limit) never matches
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hit <= 1'b0;
    end else begin
      hit <= win_en && (base <= limit) && (addr >= base) && (addr <= limit);
    end
  end
endmodule

/* File: logic/bridge_err_clkrun_privmem_regs.sv */
`timescale 1ns/100ps
`include "bridge_err_map.svh"
// How it works
// - bit0 address parity, all W1C, reset zero
// - bit1 posted write data parity
// - bit2 posted write not delivered
// - bit3 target abort on posted write
// - bit4 master abort on posted write
// - bit5 delayed write not delivered
// - bit6 delayed read failed
// - bit7 master failed to repeat
// - clock-run bit0 secondary clock stopped status
// - clock-run bit1 secondary pin enable
// - bit2 zero lets primary stop after secondary
// - clock-run bit3 primary pin enable
// - bit4 selects request or idle stop
// - window enabled by control bit or strap
// - base low bits 15:4 writable, 3:0 0001b
// - limit low 15:4 writable, 3:0 zero
// - base high 32 bits, resets to one
// - limit high 32 bits, resets to zero
// - reset base exceeds limit, window off
// - error output needs unmasked and enable
// - timeout after 2^24 or programmed retries
module bridge_err_clkrun_privmem_regs
  import bridge_err_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire bridge_err_pkg::cfg_req_t cfg_req,
  output logic [31:0]                cfg_rdata,
  input  wire bridge_err_pkg::err_evt_t err_evt,
  input  wire logic                  retry_attempt,
  input  wire logic                  retry_done,
  input  wire logic [24:0]           retry_limit,
  output logic                       retry_timeout,
  input  wire logic [7:0]            err_mask,
  input  wire logic                  serr_enable,
  output logic                       primary_system_error_n,
  input  wire logic                  pri_stop_request,
  input  wire logic                  sec_bus_idle,
  input  wire logic                  pri_req_pending,
  output logic                       sec_clk_stop,
  output logic                       pri_clk_stop_ok,
  output logic                       sec_clkrun_pin_en,
  output logic                       pri_clkrun_pin_en,
  input  wire logic                  chip_control_pvt_en,
  input  wire logic                  private_device_strap,
  input  wire logic [63:0]           fwd_addr,
  output logic                       pvt_hit
);
  import bridge_err_pkg::*;

  logic [7:0]  err_status_r;   // sticky cause byte
  logic [7:0]  clkrun_r;       // clock-run control/status
  logic [15:0] pbase_lo_r;     // window base, address bits 31:20 in 15:4
  logic [15:0] plimit_lo_r;    // window limit, address bits 31:20 in 15:4
  logic [31:0] pbase_hi_r;     // window base bits 63:32
  logic [31:0] plimit_hi_r;    // window limit bits 63:32
  logic [24:0] retry_cnt_r;    // attempts so far on current delivery
  clk_state_t  cs_r;           // clock-stop sequencer
  logic [7:0]  wr_b [0:3];     // write data per byte lane
  logic [3:0]  hit_lo;         // one-hot dword hit: 74h, 70h, 6Ch, 68h
  logic        dw68, dw6c, dw70, dw74;
  logic [7:0]  evt_vec;
  logic [7:0]  w1c;
  logic [63:0] base64, limit64;
  logic        win_en;

  // byte lanes of the write data
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wr_b[g] = cfg_req.wdata[8*g +: 8];
    end
  endgenerate

  // dword decode; the status and clock-run bytes sit in lanes 2 and 3 of 68h
  assign dw68 = cfg_req.addr[7:2] == 6'(`OFS_ERR_STATUS >> 2);
  assign dw6c = cfg_req.addr[7:2] == 6'(`OFS_PBASE_LO >> 2);
  assign dw70 = cfg_req.addr[7:2] == 6'(`OFS_PBASE_HI >> 2);
  assign dw74 = cfg_req.addr[7:2] == 6'(`OFS_PLIMIT_HI >> 2);
  assign hit_lo = {dw74, dw70, dw6c, dw68};

  // event vector and byte of ones written to clear
  assign evt_vec = err_evt;
  assign w1c = (cfg_req.wr && dw68 && cfg_req.be[2]) ? wr_b[2] : 8'h00;

  // sticky causes: a new event wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      err_status_r <= 8'h00;
    end else begin
      // bits 0..7 set by their causes
      // likewise
      err_status_r <= (err_status_r & ~w1c) | evt_vec;
    end
  end

  // retry counter; times out at the programmed or default maximum
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      retry_cnt_r   <= 25'h0000000;
      retry_timeout <= 1'b0;
    end else begin
      retry_timeout <= 1'b0;
      if (retry_done) begin
        retry_cnt_r <= 25'h0000000;
      end else if (retry_attempt) begin
        // zero limit means the default of 2^24 attempts
        if (retry_cnt_r + 25'h0000001 >=
            ((retry_limit == 25'h0000000) ? `RETRY_MAX_DEF : retry_limit)) begin
          retry_timeout <= 1'b1;
          retry_cnt_r   <= 25'h0000000;
        end else begin
          retry_cnt_r <= retry_cnt_r + 25'h0000001;
        end
      end
    end
  end

  // system error output, active low, registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      primary_system_error_n <= 1'b1;
    end else begin
      primary_system_error_n <= !(serr_enable && |(err_status_r & ~err_mask));
    end
  end

  // clock-stop sequencer; the stopped bit is hardware-tracked and also writable
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cs_r <= CS_RUN;
    end else begin
      case (cs_r)
        CS_RUN: begin
          // mode 0 waits for a primary request, mode 1 for idle
          if (clkrun_r[`CR_MODE] ? (sec_bus_idle && !pri_req_pending) : pri_stop_request) begin
            cs_r <= CS_SEC_STOP;
          end
        end
        CS_SEC_STOP: begin
          if (pri_req_pending || !clkrun_r[`CR_SEC_STOPPED]) begin
            cs_r <= CS_RUN;
          end else if (!clkrun_r[`CR_PRI_KEEP]) begin
            cs_r <= CS_PRI_STOP;
          end
        end
        CS_PRI_STOP: begin
          if (pri_req_pending || clkrun_r[`CR_PRI_KEEP] || !clkrun_r[`CR_SEC_STOPPED]) begin
            cs_r <= CS_RUN;
          end
        end
        default: cs_r <= CS_RUN;
      endcase
    end
  end

  // clock-run register; status bit follows the sequencer unless written
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clkrun_r <= 8'h00;
    end else if (cfg_req.wr && dw68 && cfg_req.be[3]) begin
      clkrun_r <= wr_b[3] & `CR_WMASK;
    end else if (cs_r == CS_RUN && !clkrun_r[`CR_SEC_STOPPED] &&
                 (clkrun_r[`CR_MODE] ? (sec_bus_idle && !pri_req_pending)
                                     : pri_stop_request)) begin
      clkrun_r[`CR_SEC_STOPPED] <= 1'b1;
    end else if (cs_r != CS_RUN && pri_req_pending) begin
      clkrun_r[`CR_SEC_STOPPED] <= 1'b0;
    end
  end

  // clock-run outputs, registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sec_clk_stop      <= 1'b0;
      pri_clk_stop_ok   <= 1'b0;
      sec_clkrun_pin_en <= 1'b0;
      pri_clkrun_pin_en <= 1'b0;
    end else begin
      sec_clk_stop      <= clkrun_r[`CR_SEC_STOPPED];
      pri_clk_stop_ok   <= clkrun_r[`CR_SEC_STOPPED] && !clkrun_r[`CR_PRI_KEEP];
      sec_clkrun_pin_en <= clkrun_r[`CR_SEC_PIN_EN];
      pri_clkrun_pin_en <= clkrun_r[`CR_PRI_PIN_EN];
    end
  end

  // private window low halves: only bits 15:4 take writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pbase_lo_r  <= `PBASE_LO_RST;
      plimit_lo_r <= `PLIMIT_LO_RST;
    end else if (cfg_req.wr && dw6c) begin
      if (cfg_req.be[0]) pbase_lo_r[7:4]    <= wr_b[0][7:4];
      if (cfg_req.be[1]) pbase_lo_r[15:8]   <= wr_b[1];
      if (cfg_req.be[2]) plimit_lo_r[7:4]   <= wr_b[2][7:4];
      if (cfg_req.be[3]) plimit_lo_r[15:8]  <= wr_b[3];
    end
  end

  // upper halves, fully writable per byte lane
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pbase_hi_r  <= `PBASE_HI_RST;
      plimit_hi_r <= `PLIMIT_HI_RST;
    end else if (cfg_req.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (dw70 && cfg_req.be[i]) pbase_hi_r[8*i +: 8]  <= wr_b[i];
        if (dw74 && cfg_req.be[i]) plimit_hi_r[8*i +: 8] <= wr_b[i];
      end
    end
  end

  // read mux; unmapped dwords return zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cfg_rdata <= 32'h00000000;
    end else if (cfg_req.rd) begin
      case (hit_lo)
        4'h1:    cfg_rdata <= {clkrun_r, err_status_r, 16'h0000};
        4'h2:    cfg_rdata <= {plimit_lo_r[15:4], 4'h0, pbase_lo_r[15:4], 4'h1};
        4'h4:    cfg_rdata <= pbase_hi_r;
        4'h8:    cfg_rdata <= plimit_hi_r;
        default: cfg_rdata <= 32'h00000000;
      endcase
    end
  end

  // assembled 64-bit window; low 20 bits implied
  assign base64  = {pbase_hi_r, pbase_lo_r[15:4], 20'h00000};
  assign limit64 = {plimit_hi_r, plimit_lo_r[15:4], `PLIMIT_LOW_ONES};
  assign win_en  = chip_control_pvt_en || private_device_strap;

  private_window_match u_match (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .base    (base64),
    .limit   (limit64),
    .win_en  (win_en),
    .addr    (fwd_addr),
    .hit     (pvt_hit)
  );

  // assertions; each one watches what the block itself drives
  a_sticky_set: assert property (@(posedge sys_clk) disable iff (!resetn)
    err_evt[0] |=> err_status_r[0])
    else $error("address parity cause not set");
  a_w1c_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    (w1c[3] && !err_evt[3]) |=> !err_status_r[3])
    else $error("w1c did not clear");
  a_hold_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
    (err_status_r[5] && !w1c[5]) |=> err_status_r[5])
    else $error("cause lost");
  // every cause raised in one cycle shows in the byte the next, even against a clear
  a_evt_sets: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 ((err_status_r & $past(evt_vec)) == $past(evt_vec)))
    else $error("cause not logged");
  a_serr_drive: assert property (@(posedge sys_clk) disable iff (!resetn)
    (serr_enable && |(err_status_r & ~err_mask)) |=> !primary_system_error_n)
    else $error("serr not asserted");
  a_serr_quiet: assert property (@(posedge sys_clk) disable iff (!resetn)
    !serr_enable |=> primary_system_error_n)
    else $error("serr without enable");
  a_retry_cause: assert property (@(posedge sys_clk) disable iff (!resetn)
    retry_timeout |-> $past(retry_attempt))
    else $error("timeout without attempt");
  a_pri_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    clkrun_r[`CR_PRI_KEEP] |=> !pri_clk_stop_ok)
    else $error("primary stop while kept");
  a_pri_after_sec: assert property (@(posedge sys_clk) disable iff (!resetn)
    pri_clk_stop_ok |-> sec_clk_stop)
    else $error("primary stop before secondary");
  a_pin_en: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 sec_clkrun_pin_en == $past(clkrun_r[`CR_SEC_PIN_EN]))
    else $error("pin enable");
  a_pri_pin: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 pri_clkrun_pin_en == $past(clkrun_r[`CR_PRI_PIN_EN]))
    else $error("primary pin enable");
  a_sec_status: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 sec_clk_stop == $past(clkrun_r[`CR_SEC_STOPPED]))
    else $error("secondary stop output");
  a_mode_request: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cs_r == CS_RUN && !clkrun_r[`CR_MODE] && !pri_stop_request) |=> cs_r == CS_RUN)
    else $error("stop without request");
  a_mode_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cs_r == CS_RUN && clkrun_r[`CR_MODE] && !(sec_bus_idle && !pri_req_pending))
    |=> cs_r == CS_RUN)
    else $error("stop while busy");
  a_lo_ro_bits: assert property (@(posedge sys_clk) disable iff (!resetn)
    (cfg_req.rd && dw6c) |=> (cfg_rdata[3:0] == 4'h1 && cfg_rdata[19:16] == 4'h0))
    else $error("ro bits changed");
  a_reset_empty: assert property (@(posedge sys_clk)
    !resetn |=> (base64 > limit64))
    else $error("window open after reset");
  a_no_hit_empty: assert property (@(posedge sys_clk) disable iff (!resetn)
    (base64 > limit64) |=> !pvt_hit)
    else $error("hit on empty window");
  a_win_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(chip_control_pvt_en || private_device_strap) |=> !pvt_hit)
    else $error("hit while window disabled");
  // cover points for the main scenarios
  c_serr: cover property (@(posedge sys_clk) disable iff (!resetn) !primary_system_error_n);
  c_sec_stop: cover property (@(posedge sys_clk) disable iff (!resetn) cs_r == CS_SEC_STOP);
  c_pri_stop: cover property (@(posedge sys_clk) disable iff (!resetn) pri_clk_stop_ok);
  c_hit: cover property (@(posedge sys_clk) disable iff (!resetn) pvt_hit);
endmodule

/* File: tb/bus_far_model.sv */
`timescale 1ns/100ps
// far-side agents: report error causes and retry attempts to the bank
module bus_far_model
  import bridge_err_pkg::*;
(
  input  wire logic                sys_clk,
  output bridge_err_pkg::err_evt_t err_evt,
  output logic                     retry_attempt,
  output logic                     retry_done
);
  import bridge_err_pkg::*;
  // quiet until a test asks for traffic
  initial begin
    err_evt       = '0;
    retry_attempt = 1'b0;
    retry_done    = 1'b0;
  end
  // one-cycle pulse on cause n, launched off the falling edge
  task automatic pulse_evt(input int n);
    @(negedge sys_clk);
    err_evt    = '0;
    err_evt[n] = 1'b1;
    @(negedge sys_clk);
    err_evt    = '0;
  endtask
  // n attempts spaced by gap plus one idle cycles, so both prompt and slow agents occur
  task automatic retries(input int n, input int gap, input bit done);
    repeat (n) begin
      @(negedge sys_clk);
      retry_attempt = 1'b1;
      @(negedge sys_clk);
      retry_attempt = 1'b0;
      repeat (gap) @(negedge sys_clk);
    end
    if (done) begin
      @(negedge sys_clk);
      retry_done = 1'b1;
      @(negedge sys_clk);
      retry_done = 1'b0;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
// bench: reads go through a note queue, level flags are compared inline
module tb_top;
  import bridge_err_pkg::*;
  typedef struct packed { logic [31:0] e; logic [31:0] m; } note_t;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  cfg_req_t    req     = '0;
  err_evt_t    ev;
  logic [31:0] rdata;
  logic        rty, rdone, tmo, serr_n, sstop, pok, spin, ppin, hit, rd_d;
  logic [24:0] rlim    = 25'h0000003;
  logic [7:0]  mask    = 8'h00;
  logic        sen     = 1'b1;
  logic        pstop   = 1'b0;
  logic        idle    = 1'b0;
  logic        pend    = 1'b0;
  logic        ctl_en  = 1'b0;
  logic        strap   = 1'b0;
  logic [63:0] faddr   = '0;
  logic [31:0] rnd     = 32'hF55C;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          tmo_cnt    = 0;
  note_t       notes[$];
  logic [63:0] atab[4] = '{64'h12300000, 64'h124FFFFF, 64'h12500000, 64'h122FFFFF};
  logic        htab[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  bridge_err_clkrun_privmem_regs bridge_err_clkrun_privmem_regs_i (
    .sys_clk(sys_clk), .resetn(resetn), .cfg_req(req), .cfg_rdata(rdata), .err_evt(ev),
    .retry_attempt(rty), .retry_done(rdone), .retry_limit(rlim), .retry_timeout(tmo),
    .err_mask(mask), .serr_enable(sen), .primary_system_error_n(serr_n),
    .pri_stop_request(pstop), .sec_bus_idle(idle), .pri_req_pending(pend),
    .sec_clk_stop(sstop), .pri_clk_stop_ok(pok), .sec_clkrun_pin_en(spin),
    .pri_clkrun_pin_en(ppin), .chip_control_pvt_en(ctl_en), .private_device_strap(strap),
    .fwd_addr(faddr), .pvt_hit(hit));
  bus_far_model bus_far_model_i (
    .sys_clk(sys_clk), .err_evt(ev), .retry_attempt(rty), .retry_done(rdone));
  // fibonacci shift register for write data
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk32(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("MISMATCH cfg_rdata exp %h got %h", e & m, g & m);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge sys_clk);
    req = '{wr:1'b1, rd:1'b0, addr:a, be:b, wdata:d};
    @(negedge sys_clk);
    req = '0;
  endtask
  // the note goes in with the request; the monitor takes it when data lands
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(negedge sys_clk);
    notes.push_back('{e:e, m:m});
    req = '{wr:1'b0, rd:1'b1, addr:a, be:4'hF, wdata:32'h0};
    @(negedge sys_clk);
    req = '0;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // read data is registered: it is checked on the falling edge half a cycle after the taking edge
  always @(posedge sys_clk) rd_d <= resetn & req.rd;
  always @(negedge sys_clk) begin
    if (rd_d === 1'b1) begin
      if (notes.size() == 0) begin
        fail_count++;
        $display("MISMATCH cfg_rdata exp note got none");
      end else begin
        chk32(notes[0].e, notes[0].m, rdata);
        void'(notes.pop_front());
      end
    end
  end
  always @(posedge sys_clk) if (tmo === 1'b1) tmo_cnt++;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog sized well beyond the roughly three hundred cycles of tests
  initial begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
  initial begin
    wait_cyc(20);
    resetn = 1'b1;
    chk1("serr_n", 1'b1, serr_n);
    rd(8'h68, 32'h0, 32'hFFFF0000);
    rd(8'h6C, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h70, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h74, 32'h0, 32'hFFFFFFFF);
    rd(8'h80, 32'h0, 32'hFFFFFFFF);
    strap = 1'b1;
    faddr = 64'h100000000;
    wait_cyc(3);
    chk1("pvt_hit", 1'b0, hit);
    strap = 1'b0;
    $display("test reset done");
    // each cause: logged, raises the error output, cleared by writing one
    for (int i = 0; i < 8; i++) begin
      bus_far_model_i.pulse_evt(i);
      wait_cyc(3);
      chk1("serr_n", 1'b0, serr_n);
      rd(8'h68, 32'h1 << (16 + i), 32'h00FF0000);
      wr(8'h68, 4'b0100, 32'h1 << (16 + i));
      rd(8'h68, 32'h0, 32'h00FF0000);
      wait_cyc(3);
      chk1("serr_n", 1'b1, serr_n);
    end
    // masked cause and disabled enable each keep the output quiet
    mask = 8'h08;
    bus_far_model_i.pulse_evt(3);
    wait_cyc(3);
    chk1("serr_n", 1'b1, serr_n);
    mask = 8'h00;
    sen  = 1'b0;
    bus_far_model_i.pulse_evt(5);
    wait_cyc(3);
    chk1("serr_n", 1'b1, serr_n);
    rd(8'h68, 32'h00280000, 32'h00FF0000);
    wr(8'h68, 4'b0100, 32'h00FF0000);
    sen = 1'b1;
    $display("test status done");
    // random clock-run control with the stop conditions held off
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(8'h68, 4'b1000, {rnd[7:1], 1'b0, 24'h0});
      rd(8'h68, {3'b000, rnd[4:1], 1'b0, 24'h0}, 32'hFF000000);
      chk1("sec_pin", rnd[1], spin);
      chk1("pri_pin", rnd[3], ppin);
    end
    wr(8'h68, 4'b1000, 32'h10000000);
    idle = 1'b1;
    wait_cyc(4);
    chk1("sec_stop", 1'b1, sstop);
    chk1("pri_ok", 1'b1, pok);
    rd(8'h68, 32'h11000000, 32'hFF000000);
    pend = 1'b1;
    wait_cyc(4);
    chk1("sec_stop", 1'b0, sstop);
    pend = 1'b0;
    wr(8'h68, 4'b1000, 32'h04000000);
    wait_cyc(4);
    chk1("sec_stop", 1'b0, sstop);
    pstop = 1'b1;
    wait_cyc(4);
    chk1("sec_stop", 1'b1, sstop);
    chk1("pri_ok", 1'b0, pok);
    pstop = 1'b0;
    idle  = 1'b0;
    $display("test clock run done");
    // window registers: random read-back, then an inclusive range table
    rnd = lfsr(rnd);
    wr(8'h6C, 4'hF, rnd);
    rd(8'h6C, {rnd[31:20], 4'h0, rnd[15:4], 4'h1}, 32'hFFFFFFFF);
    wr(8'h70, 4'hF, ~rnd);
    rd(8'h70, ~rnd, 32'hFFFFFFFF);
    wr(8'h74, 4'hF, rnd);
    rd(8'h74, rnd, 32'hFFFFFFFF);
    wr(8'h6C, 4'hF, 32'h12401230);
    wr(8'h70, 4'hF, 32'h0);
    wr(8'h74, 4'hF, 32'h0);
    for (int en = 0; en < 4; en++) begin
      ctl_en = en[0];
      strap  = en[1];
      for (int j = 0; j < 4; j++) begin
        faddr = atab[j];
        wait_cyc(3);
        chk1("pvt_hit", htab[j] & (en != 0), hit);
      end
    end
    $display("test window done");
    // retries below the limit end quietly; reaching it times out once
    bus_far_model_i.retries(2, 0, 1'b1);
    wait_cyc(4);
    chk1("timeout", 1'b0, tmo_cnt != 0);
    bus_far_model_i.retries(3, 2, 1'b0);
    wait_cyc(4);
    chk1("timeout", 1'b1, tmo_cnt == 1);
    $display("test retry done");
    // a second reset mid-run drops a logged cause and restores the window
    bus_far_model_i.pulse_evt(6);
    wait_cyc(2);
    chk1("serr_n", 1'b0, serr_n);
    resetn = 1'b0;
    wait_cyc(2);
    resetn = 1'b1;
    chk1("serr_n", 1'b1, serr_n);
    rd(8'h68, 32'h0, 32'hFFFF0000);
    rd(8'h6C, 32'h00000001, 32'hFFFFFFFF);
    rd(8'h70, 32'h00000001, 32'hFFFFFFFF);
    $display("test second reset done");
    wait_cyc(3);
    tally_and_finish();
  end
endmodule
